// >>> logic/scc_regs.sv
// Purpose: indexed system control and pointer register bank
// Assumes: host index/data strobes from same clock; lock key from lock_key_register
// Notes: reserved bits read as zero
module scc_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] lock_key_register,
  input wire logic [7:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic latch_delay_t1,
  input wire logic upper_display_start_set,
  input wire logic upper_host_base_set,
  input wire logic enhanced_mode,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic bank_open,
  output logic enhanced_access_on,
  output logic wait_state_select,
  output logic addr_latch_t1,
  output logic interlace_select,
  output logic interlace_start_active,
  output logic [9:0] screen_width_hi_bits,
  output logic horiz_counter_double,
  output logic pointer_on,
  output logic pointer_visible,
  output logic pointer_right_storage,
  output logic [10:0] pointer_x_coord,
  output logic [10:0] pointer_y_coord,
  output logic [23:0] pointer_fore_colour,
  output logic [23:0] pointer_back_colour,
  output logic [11:0] pointer_store_addr,
  output logic [5:0] pattern_x_skip,
  output logic [5:0] pattern_y_skip,
  output logic [1:0] display_start_hi_bits,
  output logic display_start_hi_valid,
  output logic [1:0] host_base_hi_bits,
  output logic host_base_hi_valid,
  output logic [7:0] bios_scratch_a,
  output logic [7:0] bios_scratch_b
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sys_cfg;
    logic [7:0] bios_a;
    logic [7:0] display_mode_control;
    logic [7:0] extended_display_mode;
    logic [7:0] ptr_mode;
    logic [7:0] orgx_h;
    logic [7:0] orgx_l;
    logic [7:0] orgy_h;
    logic [7:0] orgy_l;
    logic [10:0] pos_x;
    logic [10:0] pos_y;
    logic [2:0][7:0] fg;
    logic [2:0][7:0] bg;
    logic [1:0] stk;
    logic [7:0] sta_h;
    logic [7:0] sta_l;
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] ext_sctl;
    logic [7:0] bios_b;
    logic [7:0] mctl_1;
    logic [7:0] rdata;
    logic hit;
  } scc_state_t;

  scc_state_t st_ff;
  scc_state_t nxt_st;
  logic unlocked;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] rd_mux;
  logic rd_hit;

  // ****************************************************************
  // protection
  // ****************************************************************
  assign unlocked = lock_key_register[7:scc_pkg::KEY_LSB] == scc_pkg::KEY_PATTERN;
  assign wr_ok = reg_wr && unlocked;
  assign rd_ok = reg_rd && unlocked;

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = scc_pkg::RST_ZERO;
    unique case (reg_index)
      scc_pkg::IDX_SYS_CFG: rd_mux = st_ff.sys_cfg & scc_pkg::MASK_SYS_CFG;
      scc_pkg::IDX_BIOS_A: rd_mux = st_ff.bios_a;
      scc_pkg::IDX_DISPLAY_MODE_CONTROL: rd_mux = st_ff.display_mode_control & scc_pkg::MASK_DISPLAY_MODE_CONTROL;
      scc_pkg::IDX_EXTENDED_DISPLAY_MODE: rd_mux = st_ff.extended_display_mode & scc_pkg::MASK_EXTENDED_DISPLAY_MODE;
      scc_pkg::IDX_PTR_MODE: rd_mux = st_ff.ptr_mode & scc_pkg::MASK_PTR_MODE;
      scc_pkg::IDX_ORGX_H: rd_mux = st_ff.orgx_h & scc_pkg::MASK_HI3;
      scc_pkg::IDX_ORGX_L: rd_mux = st_ff.orgx_l;
      scc_pkg::IDX_ORGY_H: rd_mux = st_ff.orgy_h & scc_pkg::MASK_HI3;
      scc_pkg::IDX_ORGY_L: rd_mux = st_ff.orgy_l;
      scc_pkg::IDX_FG_STK: rd_mux = st_ff.fg[st_ff.stk];
      scc_pkg::IDX_BG_STK: rd_mux = st_ff.bg[st_ff.stk];
      scc_pkg::IDX_STA_H: rd_mux = st_ff.sta_h & scc_pkg::MASK_HI4;
      scc_pkg::IDX_STA_L: rd_mux = st_ff.sta_l;
      scc_pkg::IDX_DX: rd_mux = st_ff.dx & scc_pkg::MASK_SKIP;
      scc_pkg::IDX_DY: rd_mux = st_ff.dy & scc_pkg::MASK_SKIP;
      scc_pkg::IDX_EXT_SCTL: rd_mux = st_ff.ext_sctl & scc_pkg::MASK_EXT_SCTL;
      scc_pkg::IDX_BIOS_B: rd_mux = st_ff.bios_b;
      scc_pkg::IDX_MCTL_1: rd_mux = st_ff.mctl_1;
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.hit = rd_ok && rd_hit;
    nxt_st.rdata = rd_ok ? rd_mux : scc_pkg::RST_ZERO;
    if (rd_ok && reg_index == scc_pkg::IDX_PTR_MODE) begin
      nxt_st.stk = scc_pkg::STK_FIRST;
    end
    if (wr_ok) begin
      unique case (reg_index)
        scc_pkg::IDX_SYS_CFG: nxt_st.sys_cfg = reg_wdata & scc_pkg::MASK_SYS_CFG;
        scc_pkg::IDX_BIOS_A: nxt_st.bios_a = reg_wdata;
        scc_pkg::IDX_DISPLAY_MODE_CONTROL: nxt_st.display_mode_control = reg_wdata & scc_pkg::MASK_DISPLAY_MODE_CONTROL;
        scc_pkg::IDX_EXTENDED_DISPLAY_MODE: nxt_st.extended_display_mode = reg_wdata & scc_pkg::MASK_EXTENDED_DISPLAY_MODE;
        scc_pkg::IDX_PTR_MODE: nxt_st.ptr_mode = reg_wdata & scc_pkg::MASK_PTR_MODE;
        scc_pkg::IDX_ORGX_H: nxt_st.orgx_h = reg_wdata & scc_pkg::MASK_HI3;
        scc_pkg::IDX_ORGX_L: nxt_st.orgx_l = reg_wdata;
        scc_pkg::IDX_ORGY_H: begin
          nxt_st.orgy_h = reg_wdata & scc_pkg::MASK_HI3;
          nxt_st.pos_x = {st_ff.orgx_h[2:0], st_ff.orgx_l};
          nxt_st.pos_y = {reg_wdata[2:0], st_ff.orgy_l};
        end
        scc_pkg::IDX_ORGY_L: nxt_st.orgy_l = reg_wdata;
        scc_pkg::IDX_FG_STK: begin
          nxt_st.fg[st_ff.stk] = reg_wdata;
          nxt_st.stk = (st_ff.stk == scc_pkg::STK_LAST) ? scc_pkg::STK_FIRST : st_ff.stk + 2'h1;
        end
        scc_pkg::IDX_BG_STK: begin
          nxt_st.bg[st_ff.stk] = reg_wdata;
          nxt_st.stk = (st_ff.stk == scc_pkg::STK_LAST) ? scc_pkg::STK_FIRST : st_ff.stk + 2'h1;
        end
        scc_pkg::IDX_STA_H: nxt_st.sta_h = reg_wdata & scc_pkg::MASK_HI4;
        scc_pkg::IDX_STA_L: nxt_st.sta_l = reg_wdata;
        scc_pkg::IDX_DX: nxt_st.dx = reg_wdata & scc_pkg::MASK_SKIP;
        scc_pkg::IDX_DY: nxt_st.dy = reg_wdata & scc_pkg::MASK_SKIP;
        scc_pkg::IDX_EXT_SCTL: nxt_st.ext_sctl = reg_wdata & scc_pkg::MASK_EXT_SCTL;
        scc_pkg::IDX_BIOS_B: nxt_st.bios_b = reg_wdata;
        scc_pkg::IDX_MCTL_1: nxt_st.mctl_1 = reg_wdata;
        default: nxt_st.hit = nxt_st.hit;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.sys_cfg <= scc_pkg::RST_SYS_CFG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = st_ff.rdata;
  assign reg_hit = st_ff.hit;
  assign bank_open = unlocked;
  assign enhanced_access_on = st_ff.sys_cfg[scc_pkg::SC_ENH_BIT];
  assign wait_state_select = st_ff.sys_cfg[scc_pkg::SC_WAIT_BIT];
  assign addr_latch_t1 = !wait_state_select || latch_delay_t1;
  assign interlace_select = st_ff.display_mode_control[scc_pkg::MC_INTL_BIT];
  assign interlace_start_active = interlace_select;
  assign screen_width_hi_bits = {st_ff.ext_sctl[5:4],
    (st_ff.ext_sctl[5:4] == 2'h0) ? st_ff.extended_display_mode[scc_pkg::EM_LSW8_BIT] : 1'b0, 7'h00};
  assign horiz_counter_double = st_ff.extended_display_mode[scc_pkg::EM_HX2_BIT];
  assign pointer_on = st_ff.ptr_mode[scc_pkg::PM_ON_BIT];
  assign pointer_visible = pointer_on && enhanced_mode;
  assign pointer_right_storage = st_ff.ptr_mode[scc_pkg::PM_RIGHT_BIT];
  assign pointer_x_coord = st_ff.pos_x;
  assign pointer_y_coord = st_ff.pos_y;
  assign pointer_fore_colour = st_ff.fg;
  assign pointer_back_colour = st_ff.bg;
  assign pointer_store_addr = {st_ff.sta_h[3:0], st_ff.sta_l};
  assign pattern_x_skip = st_ff.dx[5:0];
  assign pattern_y_skip = st_ff.dy[5:0];
  assign display_start_hi_bits = st_ff.ext_sctl[1:0];
  assign display_start_hi_valid = !upper_display_start_set;
  assign host_base_hi_bits = st_ff.ext_sctl[3:2];
  assign host_base_hi_valid = !upper_host_base_set;
  assign bios_scratch_a = st_ff.bios_a;
  assign bios_scratch_b = st_ff.bios_b;
endmodule

// >>> logic/scc_pkg.sv
// Purpose: constants for the system control and pointer register bank
// Assumes: byte-wide indexed register port, one clock
// Notes: indices are the bank's own register indices
package scc_pkg;
  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [7:0] IDX_SYS_CFG = 8'h40;
  localparam logic [7:0] IDX_BIOS_A = 8'h41;
  localparam logic [7:0] IDX_DISPLAY_MODE_CONTROL = 8'h42;
  localparam logic [7:0] IDX_EXTENDED_DISPLAY_MODE = 8'h43;
  localparam logic [7:0] IDX_PTR_MODE = 8'h45;
  localparam logic [7:0] IDX_ORGX_H = 8'h46;
  localparam logic [7:0] IDX_ORGX_L = 8'h47;
  localparam logic [7:0] IDX_ORGY_H = 8'h48;
  localparam logic [7:0] IDX_ORGY_L = 8'h49;
  localparam logic [7:0] IDX_FG_STK = 8'h4A;
  localparam logic [7:0] IDX_BG_STK = 8'h4B;
  localparam logic [7:0] IDX_STA_H = 8'h4C;
  localparam logic [7:0] IDX_STA_L = 8'h4D;
  localparam logic [7:0] IDX_DX = 8'h4E;
  localparam logic [7:0] IDX_DY = 8'h4F;
  localparam logic [7:0] IDX_EXT_SCTL = 8'h51;
  localparam logic [7:0] IDX_BIOS_B = 8'h52;
  localparam logic [7:0] IDX_MCTL_1 = 8'h53;
  // ****************************************************************
  // reset values and fields
  // ****************************************************************
  localparam logic [7:0] RST_SYS_CFG = 8'h30;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] KEY_PATTERN = 3'h5;
  localparam int KEY_LSB = 5;
  localparam int SC_ENH_BIT = 0;
  localparam int SC_WAIT_BIT = 4;
  localparam int MC_INTL_BIT = 5;
  localparam int EM_LSW8_BIT = 2;
  localparam int EM_HX2_BIT = 7;
  localparam int PM_ON_BIT = 0;
  localparam int PM_RIGHT_BIT = 4;
  localparam logic [7:0] MASK_SYS_CFG = 8'h31;
  localparam logic [7:0] MASK_DISPLAY_MODE_CONTROL = 8'h20;
  localparam logic [7:0] MASK_EXTENDED_DISPLAY_MODE = 8'h84;
  localparam logic [7:0] MASK_PTR_MODE = 8'h11;
  localparam logic [7:0] MASK_HI3 = 8'h07;
  localparam logic [7:0] MASK_HI4 = 8'h0F;
  localparam logic [7:0] MASK_SKIP = 8'h3F;
  localparam logic [7:0] MASK_EXT_SCTL = 8'h3F;
  localparam logic [1:0] STK_LAST = 2'h2;
  localparam logic [1:0] STK_FIRST = 2'h0;
endpackage

// >>> sim/scc_host_lock.sv
// Purpose: host side holder of the lock key register
// Assumes: host loads the key with a one-cycle strobe
// Notes: key is a level seen by the bank
module scc_host_lock (
  input wire logic clk,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  output logic [7:0] lock_key_register
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (key_wr) begin
      lock_key_register <= key_data;
    end
  end
endmodule

// >>> sim/scc_regs_asserts.sv
// Purpose: port checks of the register bank
// Assumes: single clock, sync reset
// Notes: bound to scc_regs
module scc_regs_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] lock_key_register,
  input wire logic [7:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic latch_delay_t1,
  input wire logic enhanced_mode,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic bank_open,
  input wire logic wait_state_select,
  input wire logic addr_latch_t1,
  input wire logic interlace_select,
  input wire logic interlace_start_active,
  input wire logic [9:0] screen_width_hi_bits,
  input wire logic pointer_on,
  input wire logic pointer_visible,
  input wire logic [10:0] pointer_x_coord,
  input wire logic [10:0] pointer_y_coord,
  input wire logic [7:0] bios_scratch_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_LOCKED_READ: assert property (reg_rd && !bank_open |=> !reg_hit && reg_rdata == 8'h00)
    else $error("read answered while locked");
  AST_LOCKED_WRITE: assert property (reg_wr && !bank_open |=> $stable(bios_scratch_a))
    else $error("write taken while locked");
  AST_KEY_OPEN: assert property (bank_open == (lock_key_register[7:5] == 3'h5))
    else $error("bank open state disagrees with key");
  AST_OPEN_READ: assert property (reg_rd && bank_open && reg_index == scc_pkg::IDX_BIOS_A
    |=> reg_hit && reg_rdata == $past(bios_scratch_a))
    else $error("scratch read wrong");
  AST_LATCH_T1: assert property (addr_latch_t1 == (!wait_state_select || latch_delay_t1))
    else $error("address latch timing wrong");
  AST_INTL: assert property (interlace_start_active == interlace_select)
    else $error("interlace start not tied to mode");
  AST_WIDTH8: assert property (screen_width_hi_bits[9:8] != 2'h0 |-> screen_width_hi_bits[7] == 1'b0)
    else $error("width bit eight not suppressed");
  AST_VISIBLE: assert property (pointer_visible == (pointer_on && enhanced_mode))
    else $error("pointer visibility wrong");
  AST_XY_HOLD: assert property (!(reg_wr && bank_open && reg_index == scc_pkg::IDX_ORGY_H)
    |=> $stable(pointer_x_coord) && $stable(pointer_y_coord))
    else $error("pointer position moved without y high write");
  CV_HIT: cover property (reg_rd && bank_open ##1 reg_hit);
  CV_XY: cover property (reg_wr && bank_open && reg_index == scc_pkg::IDX_ORGY_H);
  CV_VIS: cover property (pointer_visible);
endmodule
bind scc_regs scc_regs_asserts u_chk (.clk, .sys_rst, .lock_key_register, .reg_index, .reg_wr, .reg_rd,
  .latch_delay_t1, .enhanced_mode, .reg_rdata, .reg_hit, .bank_open, .wait_state_select, .addr_latch_t1,
  .interlace_select, .interlace_start_active, .screen_width_hi_bits, .pointer_on, .pointer_visible,
  .pointer_x_coord, .pointer_y_coord, .bios_scratch_a);

// >>> sim/test_system_control_cursor_regs.sv
// Purpose: self-checking bench of the register bank
// Assumes: strobes driven at falling edge
// Notes: host key holder drives the lock key
module test_system_control_cursor_regs;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
  logic clk = 0, sys_rst = 1, key_wr = 1, reg_wr = 0, reg_rd = 0, latch_delay_t1 = 0, enhanced_mode = 0;
  logic upper_display_start_set = 0, upper_host_base_set = 0, reg_hit, bank_open, enhanced_access_on;
  logic wait_state_select, addr_latch_t1, interlace_select, interlace_start_active, horiz_counter_double;
  logic pointer_on, pointer_visible, pointer_right_storage, display_start_hi_valid, host_base_hi_valid;
  logic [7:0] key_data = 8'h00, reg_index = 8'h00, reg_wdata = 8'h00, lock_key_register, reg_rdata;
  logic [7:0] bios_scratch_a, bios_scratch_b;
  logic [9:0] screen_width_hi_bits;
  logic [10:0] pointer_x_coord, pointer_y_coord;
  logic [23:0] pointer_fore_colour, pointer_back_colour;
  logic [11:0] pointer_store_addr;
  logic [5:0] pattern_x_skip, pattern_y_skip;
  logic [1:0] display_start_hi_bits, host_base_hi_bits;
  int n_errors = 0, compares = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  scc_host_lock i_host (.clk, .key_wr, .key_data, .lock_key_register);
  scc_regs i_dut (.clk, .sys_rst, .lock_key_register, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .latch_delay_t1,
    .upper_display_start_set, .upper_host_base_set, .enhanced_mode, .reg_rdata, .reg_hit, .bank_open,
    .enhanced_access_on, .wait_state_select, .addr_latch_t1, .interlace_select, .interlace_start_active,
    .screen_width_hi_bits, .horiz_counter_double, .pointer_on, .pointer_visible, .pointer_right_storage,
    .pointer_x_coord, .pointer_y_coord, .pointer_fore_colour, .pointer_back_colour, .pointer_store_addr,
    .pattern_x_skip, .pattern_y_skip, .display_start_hi_bits, .display_start_hi_valid, .host_base_hi_bits,
    .host_base_hi_valid, .bios_scratch_a, .bios_scratch_b);
  // ****
  // access tasks
  // ****
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    reg_index = i;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk) reg_wr = 0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m, input logic h);
    reg_index = i;
    reg_rd = 1;
    @(negedge clk) reg_rd = 0;
    `CHK("rdata", e, reg_rdata & m)
    `CHK("hit", h, reg_hit)
    @(negedge clk);
  endtask
  task automatic key(input logic [7:0] d);
    key_data = d;
    key_wr = 1;
    @(negedge clk) key_wr = 0;
    @(negedge clk);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20us;
    n_errors++;
    end_sim();
  end
  initial begin
    @(negedge clk) key_wr = 0;
    repeat (11) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    rd(scc_pkg::IDX_BIOS_A, 8'h00, 8'hFF, 1'b0);
    wr(scc_pkg::IDX_BIOS_A, 8'h5A);
    key(8'hBF);
    rd(scc_pkg::IDX_BIOS_A, 8'h00, 8'hFF, 1'b1);
    rd(scc_pkg::IDX_SYS_CFG, 8'h30, scc_pkg::MASK_SYS_CFG, 1'b1);
    `CHK("wait", 1'b1, wait_state_select)
    wr(scc_pkg::IDX_SYS_CFG, 8'h01);
    `CHK("enh", 1'b1, enhanced_access_on)
    `CHK("t1", 1'b1, addr_latch_t1)
    wr(scc_pkg::IDX_SYS_CFG, 8'h11);
    `CHK("t2", 1'b0, addr_latch_t1)
    latch_delay_t1 = 1;
    #1 `CHK("t3", 1'b1, addr_latch_t1)
    wr(scc_pkg::IDX_DISPLAY_MODE_CONTROL, 8'h20);
    `CHK("intl", 2'h3, {interlace_select, interlace_start_active})
    wr(scc_pkg::IDX_EXTENDED_DISPLAY_MODE, 8'h84);
    `CHK("hx2", 1'b1, horiz_counter_double)
    `CHK("w8", 10'h080, screen_width_hi_bits)
    wr(scc_pkg::IDX_EXT_SCTL, 8'h1F);
    `CHK("w98", 10'h100, screen_width_hi_bits)
    `CHK("ds_hb", 4'hF, {display_start_hi_bits, host_base_hi_bits})
    `CHK("valid", 2'h3, {display_start_hi_valid, host_base_hi_valid})
    upper_display_start_set = 1;
    upper_host_base_set = 1;
    #1 `CHK("invalid", 2'h0, {display_start_hi_valid, host_base_hi_valid})
    enhanced_mode = 1;
    wr(scc_pkg::IDX_PTR_MODE, 8'h11);
    `CHK("vis", 2'h3, {pointer_visible, pointer_right_storage})
    enhanced_mode = 0;
    #1 `CHK("novis", 1'b0, pointer_visible)
    wr(scc_pkg::IDX_ORGX_H, 8'h05);
    wr(scc_pkg::IDX_ORGX_L, 8'hAB);
    wr(scc_pkg::IDX_ORGY_L, 8'h34);
    `CHK("x0", 11'h000, pointer_x_coord)
    wr(scc_pkg::IDX_ORGY_H, 8'h02);
    `CHK("xy", 22'h2D5A34, {pointer_x_coord, pointer_y_coord})
    wr(scc_pkg::IDX_FG_STK, 8'h11);
    wr(scc_pkg::IDX_FG_STK, 8'h22);
    rd(scc_pkg::IDX_PTR_MODE, 8'h11, scc_pkg::MASK_PTR_MODE, 1'b1);
    wr(scc_pkg::IDX_FG_STK, 8'h33);
    `CHK("fg0", 24'h002233, pointer_fore_colour)
    wr(scc_pkg::IDX_FG_STK, 8'h44);
    wr(scc_pkg::IDX_FG_STK, 8'h55);
    `CHK("fg", 24'h554433, pointer_fore_colour)
    wr(scc_pkg::IDX_BG_STK, 8'h66);
    wr(scc_pkg::IDX_BG_STK, 8'h77);
    wr(scc_pkg::IDX_BG_STK, 8'h88);
    `CHK("bg", 24'h887766, pointer_back_colour)
    wr(scc_pkg::IDX_STA_H, 8'h0F);
    wr(scc_pkg::IDX_STA_L, 8'hFF);
    wr(scc_pkg::IDX_DX, 8'hFF);
    wr(scc_pkg::IDX_DY, 8'h2A);
    `CHK("sta_dx_dy", 24'hFFFFEA, {pointer_store_addr, pattern_x_skip, pattern_y_skip})
    wr(scc_pkg::IDX_BIOS_B, 8'hC3);
    rd(scc_pkg::IDX_BIOS_B, 8'hC3, 8'hFF, 1'b1);
    rd(8'h44, 8'h00, 8'hFF, 1'b0);
    key(8'h80);
    rd(scc_pkg::IDX_BIOS_B, 8'h00, 8'hFF, 1'b0);
    end_sim();
  end
endmodule
